// file: rtl/rrc_compositor.sv
`timescale 1ns/1ps
`default_nettype none
module rrc_compositor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic main_rd_en,
	output logic [rrc_pkg::ADDR_W-1:0] main_rd_addr,
	input wire logic [rrc_pkg::PIX_W-1:0] main_rd_data,
	output logic sec_rd_en,
	output logic [rrc_pkg::ADDR_W-1:0] sec_rd_addr,
	input wire logic [rrc_pkg::PIX_W-1:0] sec_rd_data,
	output logic pix_valid,
	output logic [rrc_pkg::PIX_W-1:0] pix_data,
	output logic pix_frame_start,
	output logic pix_line_end
);
	localparam int PW = rrc_pkg::PIX_W;
	localparam int CW = rrc_pkg::CNT_W;
	localparam int HL = rrc_pkg::HALF_LSB;

	// per-component halving, each of red, green and blue shifted right by one
	function automatic logic [PW-1:0] half(input logic [PW-1:0] p);
		half = {1'b0, p[23:17], 1'b0, p[15:9], 1'b0, p[7:1]};
	endfunction

	function automatic logic [PW-1:0] avg(input logic [PW-1:0] a, input logic [PW-1:0] b);
		logic [8:0] s;
		avg = '0;
		for (int c = 0; c < 3; c++)
		begin
			s = {1'b0, a[c*8 +: 8]} + {1'b0, b[c*8 +: 8]};
			avg[c*8 +: 8] = s[8:1];
		end
	endfunction

	// register file
	logic [16:0] ctrl_reg, ctrl_next;
	logic [31:0] mstart_reg, mstart_next, moffs_reg, moffs_next;
	logic [31:0] sstart_reg, sstart_next, soffs_reg, soffs_next;
	logic [31:0] winx_reg, winx_next, winy_reg, winy_next, panel_reg, panel_next;
	logic [15:0] ovl_reg, ovl_next;
	logic [PW-1:0] key_reg [rrc_pkg::NUM_FN];
	logic [PW-1:0] key_next [rrc_pkg::NUM_FN];
	logic [31:0] rdata_reg, rdata_next;

	// scan state
	rrc_pkg::rrc_scan_t state_reg, state_next;
	logic [CW-1:0] x_reg, x_next, y_reg, y_next;
	logic fetch_reg, fetch_next, sfetch_reg, sfetch_next;
	logic s1_valid_reg, s1_inwin_reg, s1_first_reg, s1_eol_reg;
	logic s1_valid_next, s1_inwin_next, s1_first_next, s1_eol_next;
	logic first_reg, first_next;
	logic [PW-1:0] out_reg, out_next;
	logic ov_reg, ofs_reg, oeol_reg;

	rrc_pkg::rrc_mode_t mode;
	logic win_on, inwin, last_x, last_y, frame_begin;
	logic [CW-1:0] wid_m1, hgt_m1;

	rrc_walk_if mw ();
	rrc_walk_if sw ();

	rrc_addr_walker u_main_walk (
		.clk_sys(clk_sys),
		.rst(rst),
		.w(mw.walk)
	);
	rrc_addr_walker u_sec_walk (
		.clk_sys(clk_sys),
		.rst(rst),
		.w(sw.walk)
	);

	// host register access; frame memory is never touched here, so host addresses stay linear
	always_comb
	begin
		ctrl_next = ctrl_reg;
		mstart_next = mstart_reg;
		moffs_next = moffs_reg;
		sstart_next = sstart_reg;
		soffs_next = soffs_reg;
		winx_next = winx_reg;
		winy_next = winy_reg;
		panel_next = panel_reg;
		ovl_next = ovl_reg;
		key_next = key_reg;
		rdata_next = rrc_pkg::RST_ZERO;
		if (reg_wr)
		begin
			unique case (reg_addr)
				rrc_pkg::REG_CTRL: ctrl_next = reg_wdata[16:0] & rrc_pkg::CTRL_MASK;
				rrc_pkg::REG_MAIN_START: mstart_next = reg_wdata;
				rrc_pkg::REG_MAIN_OFFS: moffs_next = reg_wdata;
				rrc_pkg::REG_SEC_START: sstart_next = reg_wdata;
				rrc_pkg::REG_SEC_OFFS: soffs_next = reg_wdata;
				rrc_pkg::REG_WIN_X: winx_next = reg_wdata;
				rrc_pkg::REG_WIN_Y: winy_next = reg_wdata;
				rrc_pkg::REG_PANEL: panel_next = reg_wdata;
				rrc_pkg::REG_OVL: ovl_next = reg_wdata[15:0] & rrc_pkg::OVL_MASK;
				default:
				begin
					for (int k = 0; k < rrc_pkg::NUM_FN; k++)
						if (reg_addr == rrc_pkg::REG_KEY0 + 8'(4 * k))
							key_next[k] = reg_wdata[PW-1:0];
				end
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				rrc_pkg::REG_CTRL: rdata_next = {15'h0000, ctrl_reg};
				rrc_pkg::REG_MAIN_START: rdata_next = mstart_reg;
				rrc_pkg::REG_MAIN_OFFS: rdata_next = moffs_reg;
				rrc_pkg::REG_SEC_START: rdata_next = sstart_reg;
				rrc_pkg::REG_SEC_OFFS: rdata_next = soffs_reg;
				rrc_pkg::REG_WIN_X: rdata_next = winx_reg;
				rrc_pkg::REG_WIN_Y: rdata_next = winy_reg;
				rrc_pkg::REG_PANEL: rdata_next = panel_reg;
				rrc_pkg::REG_OVL: rdata_next = {16'h0000, ovl_reg};
				rrc_pkg::REG_STATUS: rdata_next = {15'h0000, state_reg == rrc_pkg::SCAN_RUN, y_reg};
				default:
				begin
					for (int k = 0; k < rrc_pkg::NUM_FN; k++)
						if (reg_addr == rrc_pkg::REG_KEY0 + 8'(4 * k))
							rdata_next = {8'h00, key_reg[k]};
				end
			endcase
		end
	end

	// scan sequencer: panel order is fixed, walkers turn it into rotated fetch order
	always_comb
	begin
		mode = rrc_pkg::rrc_mode_t'(ctrl_reg[rrc_pkg::CTRL_MODE_LSB +: 2]);
		win_on = (mode == rrc_pkg::MODE_REPLACE) || (mode == rrc_pkg::MODE_OVERLAY);
		wid_m1 = panel_reg[CW-1:0] - 16'h0001;
		hgt_m1 = panel_reg[HL +: CW] - 16'h0001;
		last_x = (x_reg == wid_m1);
		last_y = (y_reg == hgt_m1);
		state_next = state_reg;
		x_next = x_reg;
		y_next = y_reg;
		frame_begin = 1'b0;
		fetch_next = 1'b0;
		first_next = first_reg;
		mw.step_pix = 1'b0;
		mw.step_line = 1'b0;
		sw.step_pix = 1'b0;
		sw.step_line = 1'b0;
		unique case (state_reg)
			rrc_pkg::SCAN_IDLE:
			begin
				x_next = '0;
				y_next = '0;
				if (ctrl_reg[rrc_pkg::CTRL_RUN_BIT])
				begin
					frame_begin = 1'b1;
					state_next = rrc_pkg::SCAN_RUN;
					fetch_next = 1'b1;
					first_next = 1'b1;
				end
			end
			rrc_pkg::SCAN_RUN:
			begin
				first_next = 1'b0;
				// secondary walker only moves on pixels it really fetched
				sw.step_line = sfetch_reg && (x_reg == winx_reg[HL +: CW]);
				sw.step_pix = sfetch_reg && !sw.step_line;
				if (last_x)
				begin
					x_next = '0;
					y_next = y_reg + 16'h0001;
					mw.step_line = 1'b1;
				end
				else
				begin
					x_next = x_reg + 16'h0001;
					mw.step_pix = 1'b1;
				end
				if ((last_x && last_y) || !ctrl_reg[rrc_pkg::CTRL_RUN_BIT])
					state_next = rrc_pkg::SCAN_IDLE;
				else
					fetch_next = 1'b1;
			end
		endcase
		mw.frame_begin = frame_begin;
		sw.frame_begin = frame_begin;
		mw.start = mstart_reg[rrc_pkg::ADDR_W-1:0];
		mw.offset = moffs_reg[rrc_pkg::ADDR_W-1:0];
		mw.depth = ctrl_reg[rrc_pkg::CTRL_MDEPTH_LSB +: 2];
		mw.rot = rrc_pkg::rrc_rot_t'(ctrl_reg[rrc_pkg::CTRL_MROT_LSB +: 2]);
		sw.start = sstart_reg[rrc_pkg::ADDR_W-1:0];
		sw.offset = soffs_reg[rrc_pkg::ADDR_W-1:0];
		sw.depth = ctrl_reg[rrc_pkg::CTRL_SDEPTH_LSB +: 2];
		sw.rot = rrc_pkg::rrc_rot_t'(ctrl_reg[rrc_pkg::CTRL_SROT_LSB +: 2]);
		s1_valid_next = fetch_reg;
		s1_inwin_next = sfetch_reg;
		s1_first_next = fetch_reg && first_reg;
		s1_eol_next = fetch_reg && last_x;
		// window test on the next pixel, so the secondary fetch leaves a flop
		inwin = win_on && (x_next >= winx_reg[CW-1:0]) && (x_next <= winx_reg[HL +: CW])
			&& (y_next >= winy_reg[CW-1:0]) && (y_next <= winy_reg[HL +: CW]);
		sfetch_next = fetch_next && inwin;
	end

	// compositing on data returned one cycle after fetch
	logic [PW-1:0] sec_op, key_op, key_sel;
	logic [rrc_pkg::NUM_FN-1:0] fn_en;
	rrc_pkg::rrc_fn_t fn;
	logic any_en;
	always_comb
	begin
		fn_en = ovl_reg[rrc_pkg::OVL_EN_LSB +: rrc_pkg::NUM_FN];
		any_en = |fn_en;
		fn = rrc_pkg::FN_INV;
		for (int k = rrc_pkg::NUM_FN - 1; k >= 0; k--)
			if (fn_en[k])
				fn = rrc_pkg::rrc_fn_t'(3'(k));
		key_sel = key_reg[fn];
		sec_op = ovl_reg[rrc_pkg::OVL_SHS_BIT] ? half(sec_rd_data) : sec_rd_data;
		key_op = ovl_reg[rrc_pkg::OVL_SHM_BIT] ? half(key_sel) : key_sel;
		out_next = main_rd_data;
		if (mode == rrc_pkg::MODE_REPLACE && s1_inwin_reg)
			out_next = sec_rd_data;
		else if (mode == rrc_pkg::MODE_OVERLAY && s1_inwin_reg && any_en
			&& main_rd_data == key_sel)
		begin
			unique case (fn)
				rrc_pkg::FN_TRANS: out_next = sec_op;
				rrc_pkg::FN_AVG: out_next = avg(sec_op, key_op);
				rrc_pkg::FN_AND: out_next = sec_op & key_op;
				rrc_pkg::FN_OR: out_next = sec_op | key_op;
				rrc_pkg::FN_INV: out_next = ~sec_op;
				default: out_next = main_rd_data;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg <= '0;
			mstart_reg <= rrc_pkg::RST_ZERO;
			moffs_reg <= rrc_pkg::RST_ZERO;
			sstart_reg <= rrc_pkg::RST_ZERO;
			soffs_reg <= rrc_pkg::RST_ZERO;
			winx_reg <= rrc_pkg::RST_ZERO;
			winy_reg <= rrc_pkg::RST_ZERO;
			panel_reg <= rrc_pkg::RST_ZERO;
			ovl_reg <= '0;
			for (int k = 0; k < rrc_pkg::NUM_FN; k++)
				key_reg[k] <= '0;
			rdata_reg <= rrc_pkg::RST_ZERO;
			state_reg <= rrc_pkg::SCAN_IDLE;
			x_reg <= '0;
			y_reg <= '0;
			fetch_reg <= 1'b0;
			sfetch_reg <= 1'b0;
			first_reg <= 1'b0;
			s1_valid_reg <= 1'b0;
			s1_inwin_reg <= 1'b0;
			s1_first_reg <= 1'b0;
			s1_eol_reg <= 1'b0;
			out_reg <= '0;
			ov_reg <= 1'b0;
			ofs_reg <= 1'b0;
			oeol_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			mstart_reg <= mstart_next;
			moffs_reg <= moffs_next;
			sstart_reg <= sstart_next;
			soffs_reg <= soffs_next;
			winx_reg <= winx_next;
			winy_reg <= winy_next;
			panel_reg <= panel_next;
			ovl_reg <= ovl_next;
			key_reg <= key_next;
			rdata_reg <= rdata_next;
			state_reg <= state_next;
			x_reg <= x_next;
			y_reg <= y_next;
			fetch_reg <= fetch_next;
			sfetch_reg <= sfetch_next;
			first_reg <= first_next;
			s1_valid_reg <= s1_valid_next;
			s1_inwin_reg <= s1_inwin_next;
			s1_first_reg <= s1_first_next;
			s1_eol_reg <= s1_eol_next;
			out_reg <= s1_valid_reg ? out_next : '0;
			ov_reg <= s1_valid_reg;
			ofs_reg <= s1_first_reg;
			oeol_reg <= s1_eol_reg;
		end
	end

	assign reg_rdata = rdata_reg;
	assign main_rd_en = fetch_reg;
	assign main_rd_addr = mw.addr;
	assign sec_rd_en = sfetch_reg;
	assign sec_rd_addr = sw.addr;
	assign pix_valid = ov_reg;
	assign pix_data = out_reg;
	assign pix_frame_start = ofs_reg;
	assign pix_line_end = oeol_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence wr_then_rd(logic [7:0] a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a && !reg_wr;
	endsequence

	chk_mode_off_main: assert property (
		s1_valid_reg && mode == rrc_pkg::MODE_OFF |=> pix_data == $past(main_rd_data))
		else $error("mode off did not show main pixel");
	chk_replace_sec: assert property (
		s1_inwin_reg && mode == rrc_pkg::MODE_REPLACE |=> pix_data == $past(sec_rd_data))
		else $error("replace mode did not show secondary pixel");
	chk_key_miss_main: assert property (
		s1_valid_reg && mode == rrc_pkg::MODE_OVERLAY && main_rd_data != key_sel
		|=> pix_data == $past(main_rd_data))
		else $error("unmatched key did not show main pixel");
	chk_trans_wins: assert property (
		s1_inwin_reg && mode == rrc_pkg::MODE_OVERLAY && fn_en[0] && !ovl_reg[15]
		&& main_rd_data == key_reg[0] |=> pix_data == $past(sec_rd_data))
		else $error("transparent did not take priority");
	chk_invert_out: assert property (
		s1_inwin_reg && mode == rrc_pkg::MODE_OVERLAY && fn_en == 5'h10 && !ovl_reg[15]
		&& main_rd_data == key_reg[4] |=> pix_data == ~$past(sec_rd_data))
		else $error("invert output wrong");
	chk_rot0_step: assert property (
		mw.step_pix && !mw.frame_begin && mw.rot == rrc_pkg::ROT_0
		|=> main_rd_addr == $past(main_rd_addr) + 20'($past(mw.depth)) + 20'h00001)
		else $error("unrotated fetch step wrong");
	chk_rot90_step: assert property (
		mw.step_pix && !mw.frame_begin && mw.rot == rrc_pkg::ROT_90
		|=> main_rd_addr == $past(main_rd_addr) + $past(mw.offset))
		else $error("90 degree fetch step wrong");
	chk_frame_load: assert property (
		frame_begin |=> main_rd_en && main_rd_addr == $past(mstart_reg[19:0]) ##2 pix_frame_start)
		else $error("frame did not start at programmed address");
	chk_reg_readback: assert property (
		wr_then_rd(rrc_pkg::REG_KEY0) |=> reg_rdata == {8'h00, $past(reg_wdata[23:0], 2)})
		else $error("key register readback wrong");
endmodule
`default_nettype wire

// file: rtl/rrc_pkg.sv
package rrc_pkg;
	localparam int ADDR_W = 20;
	localparam int PIX_W = 24;
	localparam int CNT_W = 16;
	localparam int NUM_FN = 5;

	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MAIN_START = 8'h04;
	localparam logic [7:0] REG_MAIN_OFFS = 8'h08;
	localparam logic [7:0] REG_SEC_START = 8'h0C;
	localparam logic [7:0] REG_SEC_OFFS = 8'h10;
	localparam logic [7:0] REG_WIN_X = 8'h14;
	localparam logic [7:0] REG_WIN_Y = 8'h18;
	localparam logic [7:0] REG_PANEL = 8'h1C;
	localparam logic [7:0] REG_KEY0 = 8'h20;
	localparam logic [7:0] REG_OVL = 8'h34;
	localparam logic [7:0] REG_STATUS = 8'h38;

	// control fields
	localparam int CTRL_MROT_LSB = 0;
	localparam int CTRL_SDEPTH_LSB = 2;
	localparam int CTRL_SROT_LSB = 4;
	localparam int CTRL_MDEPTH_LSB = 6;
	localparam int CTRL_MODE_LSB = 8;
	localparam int CTRL_RUN_BIT = 16;
	localparam logic [16:0] CTRL_MASK = 17'h103FF;
	// overlay control fields
	localparam int OVL_EN_LSB = 0;
	localparam int OVL_SHM_BIT = 13;
	localparam int OVL_SHS_BIT = 15;
	localparam logic [15:0] OVL_MASK = 16'hA01F;
	// window and panel words: low half start/width, high half end/height
	localparam int HALF_LSB = 16;

	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		ROT_0 = 2'b00,
		ROT_90 = 2'b01,
		ROT_180 = 2'b10,
		ROT_270 = 2'b11
	} rrc_rot_t;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_REPLACE = 2'b01,
		MODE_RSVD = 2'b10,
		MODE_OVERLAY = 2'b11
	} rrc_mode_t;

	// index of each overlay function, also its priority rank
	typedef enum logic [2:0] {
		FN_TRANS = 3'b000,
		FN_AVG = 3'b001,
		FN_AND = 3'b010,
		FN_OR = 3'b011,
		FN_INV = 3'b100
	} rrc_fn_t;

	typedef enum logic [0:0] {
		SCAN_IDLE = 1'b0,
		SCAN_RUN = 1'b1
	} rrc_scan_t;
endpackage

// file: rtl/rrc_walk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rrc_walk_if;
	logic [rrc_pkg::ADDR_W-1:0] start;
	logic [rrc_pkg::ADDR_W-1:0] offset;
	logic [1:0] depth;
	rrc_pkg::rrc_rot_t rot;
	logic frame_begin;
	logic step_pix;
	logic step_line;
	logic [rrc_pkg::ADDR_W-1:0] addr;

	modport ctl (
		output start,
		output offset,
		output depth,
		output rot,
		output frame_begin,
		output step_pix,
		output step_line,
		input addr
	);
	modport walk (
		input start,
		input offset,
		input depth,
		input rot,
		input frame_begin,
		input step_pix,
		input step_line,
		output addr
	);
endinterface
`default_nettype wire

// file: rtl/rrc_addr_walker.sv
`timescale 1ns/1ps
`default_nettype none
module rrc_addr_walker (
	input wire logic clk_sys,
	input wire logic rst,
	rrc_walk_if.walk w
);
	logic [rrc_pkg::ADDR_W-1:0] addr_reg;
	logic [rrc_pkg::ADDR_W-1:0] addr_next;
	logic [rrc_pkg::ADDR_W-1:0] base_reg;
	logic [rrc_pkg::ADDR_W-1:0] base_next;
	logic [rrc_pkg::ADDR_W-1:0] bytes;
	logic [rrc_pkg::ADDR_W-1:0] pix_step;
	logic [rrc_pkg::ADDR_W-1:0] line_step;

	// bytes per pixel is the depth code plus one; steps wrap modulo the address width
	always_comb
	begin
		bytes = rrc_pkg::ADDR_W'({w.depth}) + 20'h00001;
		unique case (w.rot)
			rrc_pkg::ROT_0:
			begin
				pix_step = bytes;
				line_step = w.offset;
			end
			rrc_pkg::ROT_90:
			begin
				pix_step = w.offset;
				line_step = -bytes;
			end
			rrc_pkg::ROT_180:
			begin
				pix_step = -bytes;
				line_step = -w.offset;
			end
			rrc_pkg::ROT_270:
			begin
				pix_step = -w.offset;
				line_step = bytes;
			end
		endcase
	end

	always_comb
	begin
		addr_next = addr_reg;
		base_next = base_reg;
		if (w.frame_begin)
		begin
			addr_next = w.start;
			base_next = w.start;
		end
		else if (w.step_line)
		begin
			base_next = base_reg + line_step;
			addr_next = base_reg + line_step;
		end
		else if (w.step_pix)
		begin
			addr_next = addr_reg + pix_step;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			addr_reg <= '0;
			base_reg <= '0;
		end
		else
		begin
			addr_reg <= addr_next;
			base_reg <= base_next;
		end
	end

	assign w.addr = addr_reg;
endmodule
`default_nettype wire

// file: test/rrc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module rrc_mem_model #(
	parameter logic [7:0] SALT = 8'h00
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rd_en,
	input wire logic [rrc_pkg::ADDR_W-1:0] rd_addr,
	output logic [rrc_pkg::PIX_W-1:0] rd_data
);
	function automatic logic [23:0] pix_of(input logic [19:0] a);
		return {a[7:0] ^ SALT, a[15:8] ^ a[19:12], a[7:0] + SALT};
	endfunction

	// data only in the cycle after a fetch; flips otherwise so stale data never passes
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rd_data <= 24'h000000;
		else if (rd_en)
			rd_data <= pix_of(rd_addr);
		else
			rd_data <= ~rd_data;
	end
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic main_rd_en, sec_rd_en, pix_valid, pix_frame_start, pix_line_end;
	logic [19:0] main_rd_addr, sec_rd_addr;
	logic [23:0] main_rd_data, sec_rd_data, pix_data;
	int fail_count = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'h000023AA;
	logic [31:0] rq[$];
	logic [25:0] pq[$];
	logic [31:0] ev;
	logic [25:0] pv;
	logic rd_flag = 1'b0;
	logic [23:0] keys[5];

	always #2 clk_sys = ~clk_sys;

	rrc_compositor dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.main_rd_en(main_rd_en), .main_rd_addr(main_rd_addr), .main_rd_data(main_rd_data),
		.sec_rd_en(sec_rd_en), .sec_rd_addr(sec_rd_addr), .sec_rd_data(sec_rd_data),
		.pix_valid(pix_valid), .pix_data(pix_data), .pix_frame_start(pix_frame_start),
		.pix_line_end(pix_line_end));
	rrc_mem_model #(.SALT(8'h3C)) main_mem (.clk_sys(clk_sys), .rst(rst),
		.rd_en(main_rd_en), .rd_addr(main_rd_addr), .rd_data(main_rd_data));
	rrc_mem_model #(.SALT(8'hA5)) sec_mem (.clk_sys(clk_sys), .rst(rst),
		.rd_en(sec_rd_en), .rd_addr(sec_rd_addr), .rd_data(sec_rd_data));

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	function automatic logic [23:0] half(input logic [23:0] p);
		return {1'b0, p[23:17], 1'b0, p[15:9], 1'b0, p[7:1]};
	endfunction

	function automatic logic [23:0] mix(input int fn, input logic [23:0] s, k,
		input logic shs, shm);
		logic [23:0] a = shs ? half(s) : s;
		logic [23:0] b = shm ? half(k) : k;
		logic [23:0] v;
		for (int i = 0; i < 24; i += 8)
			v[i+:8] = 8'((9'(a[i+:8]) + 9'(b[i+:8])) >> 1);
		return (fn == 0) ? a : (fn == 1) ? v : (fn == 2) ? (a & b) : (fn == 3) ? (a | b) : ~a;
	endfunction

	// panel (r,c) to stored column x, row y for each quarter turn
	function automatic logic [19:0] addr_of(input logic [19:0] b, input int rot, bpp, sw, sh, r, c);
		int x = (rot == 0) ? c : (rot == 1) ? sw - 1 - r : (rot == 2) ? sw - 1 - c : r;
		int y = (rot == 0) ? r : (rot == 1) ? c : (rot == 2) ? sh - 1 - r : sh - 1 - c;
		return b + 20'((x + y * sw) * bpp);
	endfunction

	function automatic logic [19:0] start_of(input logic [19:0] b, input int rot, bpp, sw, sh);
		int off = sw * bpp;
		return b + 20'((rot == 1) ? off - bpp : (rot == 2) ? off * sh - bpp : (rot == 3) ? off * (sh - 1) : 0);
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	// write then read back with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		rq.push_back(d);
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	task automatic run_frame(input int mrot, mdep, srot, sdep, mode, input logic [31:0] ovl,
		input string nm);
		int pw = mrot[0] ? 3 : 4;
		int ph = mrot[0] ? 4 : 3;
		int mb = mdep + 1;
		int sb = sdep + 1;
		int ssw = srot[0] ? 3 : 2;
		int ssh = srot[0] ? 2 : 3;
		int fn = 5;
		int n = 0;
		logic [19:0] ma = 20'h00100 + 20'(rnd() & 32'h00000FFF);
		logic [19:0] sa = 20'h40000 + 20'(rnd() & 32'h00000FFF);
		logic [23:0] m, s, o;
		logic in_w;
		for (int i = 4; i >= 0; i--)
			if (ovl[i])
				fn = i;
		for (int i = 0; i < 5; i++)
			keys[i] = 24'(rnd());
		// one main pixel inside the window matches, the rest do not
		if (fn < 5)
			keys[fn] = main_mem.pix_of(addr_of(ma, mrot, mb, 4, 3, 1, 1));
		for (int i = 0; i < 5; i++)
			wr(8'h20 + 8'(4 * i), {8'h00, keys[i]});
		wr(8'h04, 32'(start_of(ma, mrot, mb, 4, 3)));
		wr(8'h08, 32'(4 * mb));
		wr(8'h0C, 32'(start_of(sa, srot, sb, ssw, ssh)));
		wr(8'h10, 32'(ssw * sb));
		wr(8'h14, {16'h0002, 16'h0001});
		wr(8'h18, {16'h0002, 16'h0000});
		wr(8'h1C, {16'(ph), 16'(pw)});
		wr(8'h34, ovl);
		for (int r = 0; r < ph; r++)
			for (int c = 0; c < pw; c++)
			begin
				in_w = (c >= 1) && (c <= 2) && (r <= 2);
				m = main_mem.pix_of(addr_of(ma, mrot, mb, 4, 3, r, c));
				s = sec_mem.pix_of(addr_of(sa, srot, sb, ssw, ssh, r, c - 1));
				o = (mode == 1 && in_w) ? s : (mode == 3 && in_w && fn < 5 && m === keys[fn]) ?
					mix(fn, s, keys[fn], ovl[15], ovl[13]) : m;
				pq.push_back({r == 0 && c == 0, c == pw - 1, o});
			end
		wr(8'h00, {15'h0000, 1'b1, 6'h00, 2'(mode), 2'(mdep), 2'(srot), 2'(sdep), 2'(mrot)});
		while (pq.size() != 0 && n < 300)
		begin
			@(posedge clk_sys);
			n++;
		end
		`CHK("pixels left", 0, pq.size())
		wr(8'h00, 32'h00000000);
		repeat (8) @(posedge clk_sys);
		$display("test %s done", nm);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(negedge clk_sys)
	begin
		if (rd_flag)
		begin
			ev = rq.pop_front();
			`CHK("reg_rdata", ev, reg_rdata)
		end
		rd_flag = reg_rd;
		if (pix_valid === 1'b1 && pq.size() != 0)
		begin
			pv = pq.pop_front();
			`CHK("pixel", pv, {pix_frame_start, pix_line_end, pix_data})
		end
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		give_verdict();
	end

	initial
	begin
		logic [31:0] v;
		logic [31:0] ovl;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a <= 8'h38; a += 4)
			rd(8'(a), 32'h00000000);
		wr(8'h00, 32'hFFFEFFFF);
		rd(8'h00, 32'h000003FF);
		wr(8'h34, 32'hFFFFFFFF);
		rd(8'h34, 32'h0000A01F);
		v = {8'h00, 24'(rnd())};
		wr(8'h20, v);
		rd(8'h20, v);
		wr_rd(8'h20, {8'h00, 24'(rnd())});
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h00000000);
		wr(8'h00, 32'h00000000);
		$display("test registers done");
		for (int r = 0; r < 4; r++)
			run_frame(r, r, 3 - r, 2, (r == 3) ? 2 : 0, 32'h0000A01F, "main rotation");
		for (int r = 0; r < 4; r++)
			run_frame(r, 0, 3 - r, r, 1, 32'h0000A01F, "replace");
		for (int fn = 0; fn < 5; fn++)
			for (int sh = 0; sh < 4; sh++)
			begin
				ovl = ((rnd() & 32'h1F) & ~((32'h1 << fn) - 1)) | (32'h1 << fn);
				ovl = ovl | (32'(sh[1]) << 15) | (32'(sh[0]) << 13);
				run_frame(0, 0, 0, 1, 3, ovl, "overlay");
			end
		run_frame(0, 0, 0, 1, 3, 32'h0000A000, "overlay without keys");
		give_verdict();
	end
endmodule
`default_nettype wire
